/* rtl/bpc_regs.sv */
// configuration and control register bank of the pack protection device
// assumes the serial front end delivers decoded one-cycle instruction strobes
// with their 16-bit data, synchronous to core_clk
`include "bpc_consts.svh"

module bpc_regs
    import bpc_pkg::*;
#(
    parameter bit FOUR_CELL = 1'b1
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // decoded instructions from the serial front end
    input  wire logic        config_write_instr,
    input  wire logic        control_write_instr,
    input  wire logic        write_enable_instr,
    input  wire logic        array_write_instr,
    input  wire logic        wrdi_instr,
    input  wire logic [15:0] wr_data,
    // supply below sleep threshold and wake detect
    input  wire logic        sleep_supply_threshold,
    input  wire logic        wake_supply,
    // register read back
    output logic      [15:0] protection_configuration,
    output logic      [15:0] pack_control,
    output logic             write_latch,
    // decoded configuration
    output logic      [1:0]  overcharge_threshold_sel,
    output logic      [1:0]  undervoltage_threshold_sel,
    output logic      [1:0]  overcurrent_threshold_sel,
    output logic      [1:0]  charge_enable_level_sel,
    output logic             charge_inhibit_disable,
    output logic             charge_inhibit_en,
    output logic             four_cell_select,
    output bpc_mv_type       overcharge_mv,
    output bpc_mv_type       undervoltage_mv,
    output bpc_mv_type       overcurrent_mv,
    output bpc_mv_type       charge_enable_mv,
    // control outputs
    output logic      [1:0]  sense_gain_sel,
    output logic             charge_fet_pin,
    output logic             discharge_fet_pin,
    output logic      [3:0]  balance_outputs,
    output logic             sleep_mode,
    output logic             normal_mode,
    output logic             store_busy
);
    localparam logic [15:0] CFG_DFLT = FOUR_CELL ? `BPC_CFG_DFLT_4CELL : `BPC_CFG_DFLT_3CELL;

    // only the two variants exist
    initial begin
        if (FOUR_CELL !== 1'b1 && FOUR_CELL !== 1'b0) begin
            $error("FOUR_CELL must be 0 or 1");
        end
    end

    bpc_state_type state_r;
    bpc_state_type state_nxt;
    logic [15:0]   ctl_r;
    logic [15:0]   ctl_nxt;
    logic          wel_r;
    logic          wel_nxt;
    logic          store_r;
    logic [15:0]   shadow_bits;

    // strobes into the bit cells, the control register and the mode sequencing
    wire recall_pulse = (state_r == BPC_ST_RECALL);
    wire cfg_wr       = config_write_instr && (state_r == BPC_ST_NORMAL);
    wire ctl_wr       = control_write_instr && (state_r == BPC_ST_NORMAL);
    wire commit       = array_write_instr && wel_r && (state_r == BPC_ST_NORMAL);
    wire sleep_go     = ctl_r[`BPC_CTL_SLEEP_BIT] && sleep_supply_threshold;

    // sixteen sram bits each with a private shadow bit
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_cfg
            bpc_shadow_bit #(
                .DFLT (CFG_DFLT[gi])
            ) u_bit (
                .core_clk   (core_clk),
                .rstn       (rstn),
                .recall     (recall_pulse),
                .wr_en      (cfg_wr),
                .wr_bit     (wr_data[gi]),
                .store      (store_r),
                .sram_bit   (protection_configuration[gi]),
                .shadow_bit (shadow_bits[gi])
            );
        end
    endgenerate

    // mode sequencing: recall once after power-up, then normal, sleep on request
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BPC_ST_RECALL: state_nxt = BPC_ST_NORMAL;
            BPC_ST_NORMAL: begin
                if (sleep_go) begin
                    state_nxt = BPC_ST_SLEEP;
                end
            end
            BPC_ST_SLEEP: begin
                if (wake_supply) begin
                    state_nxt = BPC_ST_NORMAL;
                end
            end
            default: state_nxt = BPC_ST_RECALL;
        endcase
    end

    // control register: whole word loads, cleared entering normal from sleep
    always_comb begin
        ctl_nxt = ctl_r;
        if (state_r == BPC_ST_SLEEP && state_nxt == BPC_ST_NORMAL) begin
            ctl_nxt = `BPC_CTL_RESET;
        end else if (ctl_wr) begin
            ctl_nxt = wr_data;
        end
    end

    // write-enable latch: set by its instruction, spent by the commit write
    always_comb begin
        wel_nxt = wel_r;
        if (state_r != BPC_ST_NORMAL || wrdi_instr || commit) begin
            wel_nxt = 1'b0;
        end else if (write_enable_instr) begin
            wel_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= BPC_ST_RECALL;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= `BPC_CTL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // store strobe delayed one cycle so it captures the sram after any write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wel_r   <= 1'b0;
            store_r <= 1'b0;
        end else begin
            wel_r   <= wel_nxt;
            store_r <= commit;
        end
    end

    // configuration field decode
    assign overcharge_threshold_sel   = protection_configuration[`BPC_CFG_OVC_HI:`BPC_CFG_OVC_LO];
    assign undervoltage_threshold_sel = protection_configuration[`BPC_CFG_UV_HI:`BPC_CFG_UV_LO];
    assign overcurrent_threshold_sel  = protection_configuration[`BPC_CFG_OC_HI:`BPC_CFG_OC_LO];
    assign charge_enable_level_sel    = protection_configuration[`BPC_CFG_CE_HI:`BPC_CFG_CE_LO];
    assign charge_inhibit_disable     = protection_configuration[`BPC_CFG_INH_BIT];
    assign charge_inhibit_en          = ~charge_inhibit_disable;
    assign four_cell_select           = protection_configuration[`BPC_CFG_CELL_BIT];

    // threshold lookup; undervoltage table follows the variant
    bpc_level_map #(.TABLE(`BPC_OVC_MV_TABLE)) u_ovc (
        .sel      (overcharge_threshold_sel),
        .level_mv (overcharge_mv)
    );
    bpc_level_map #(.TABLE(FOUR_CELL ? `BPC_UV4_MV_TABLE : `BPC_UV3_MV_TABLE)) u_uv (
        .sel      (undervoltage_threshold_sel),
        .level_mv (undervoltage_mv)
    );
    bpc_level_map #(.TABLE(`BPC_OC_MV_TABLE)) u_oc (
        .sel      (overcurrent_threshold_sel),
        .level_mv (overcurrent_mv)
    );
    bpc_level_map #(.TABLE(`BPC_CE_MV_TABLE)) u_ce (
        .sel      (charge_enable_level_sel),
        .level_mv (charge_enable_mv)
    );

    // control outputs straight from flops; bit 7 feeds sleep, bits 6-0 stored but unused
    assign pack_control      = ctl_r;
    assign sense_gain_sel    = ctl_r[`BPC_CTL_GAIN_HI:`BPC_CTL_GAIN_LO];
    assign charge_fet_pin    = ctl_r[`BPC_CTL_CFET_BIT];
    assign discharge_fet_pin = ctl_r[`BPC_CTL_DFET_BIT];
    assign balance_outputs   = ctl_r[`BPC_CTL_BAL_HI:`BPC_CTL_BAL_LO];

    // status views
    assign sleep_mode  = (state_r == BPC_ST_SLEEP);
    assign normal_mode = (state_r == BPC_ST_NORMAL);
    assign write_latch = wel_r;
    assign store_busy  = store_r;
endmodule

/* rtl/bpc_consts.svh */
// constants for the protection configuration and pack control register bank
// assumes inclusion by rtl files only; definitions only
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH

// configuration field positions
`define BPC_CFG_OVC_HI      15
`define BPC_CFG_OVC_LO      14
`define BPC_CFG_UV_HI       13
`define BPC_CFG_UV_LO       12
`define BPC_CFG_OC_HI       11
`define BPC_CFG_OC_LO       10
`define BPC_CFG_CE_HI       9
`define BPC_CFG_CE_LO       8
`define BPC_CFG_CELL_BIT    7
`define BPC_CFG_INH_BIT     6
`define BPC_CFG_USED_MASK   16'hffc0

// configuration defaults per variant
`define BPC_CFG_DFLT_4CELL  16'h33c0
`define BPC_CFG_DFLT_3CELL  16'h0340

// control field positions
`define BPC_CTL_BAL_HI      15
`define BPC_CTL_BAL_LO      12
`define BPC_CTL_DFET_BIT    11
`define BPC_CTL_CFET_BIT    10
`define BPC_CTL_GAIN_HI     9
`define BPC_CTL_GAIN_LO     8
`define BPC_CTL_SLEEP_BIT   7
`define BPC_CTL_RESET       16'h0000

// threshold tables in millivolts
`define BPC_OVC_MV_TABLE    {13'd4350, 13'd4300, 13'd4250, 13'd4200}
`define BPC_UV4_MV_TABLE    {13'd2250, 13'd2150, 13'd2050, 13'd1950}
`define BPC_UV3_MV_TABLE    {13'd2550, 13'd2450, 13'd2350, 13'd2250}
`define BPC_OC_MV_TABLE     {13'd150, 13'd125, 13'd100, 13'd75}
`define BPC_CE_MV_TABLE     {13'd1400, 13'd1100, 13'd800, 13'd500}

`endif

/* rtl/bpc_pkg.sv */
// types shared by the register bank modules
// assumes nothing beyond a systemverilog compiler
package bpc_pkg;
    typedef enum logic [1:0] {
        BPC_ST_RECALL = 2'b00,
        BPC_ST_NORMAL = 2'b01,
        BPC_ST_SLEEP  = 2'b10
    } bpc_state_type;

    typedef logic [12:0] bpc_mv_type;
endpackage

/* rtl/bpc_level_map.sv */
// maps a two bit selector onto one of four millivolt levels
// assumes the table is packed with code 3 in the top slot
module bpc_level_map
    import bpc_pkg::*;
#(
    parameter logic [51:0] TABLE = 52'h0
) (
    // selector
    input  wire logic [1:0] sel,
    // chosen level
    output bpc_mv_type      level_mv
);
    // plain indexed part-select, no storage
    assign level_mv = TABLE[sel*13 +: 13];
endmodule

/* rtl/bpc_shadow_bit.sv */
// one configuration bit: volatile copy paired with its own shadow bit
// assumes recall, write and store strobes are one-cycle and exclusive in intent
module bpc_shadow_bit
    import bpc_pkg::*;
#(
    parameter logic DFLT = 1'b0
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // strobes
    input  wire logic recall,
    input  wire logic wr_en,
    input  wire logic wr_bit,
    input  wire logic store,
    // state
    output logic      sram_bit,
    output logic      shadow_bit
);
    // shadow keeps its value across power cycles; reset stands for factory fill
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shadow_bit <= DFLT;
        end else if (store) begin
            shadow_bit <= sram_bit;
        end
    end

    // volatile copy: recall overrides, write only touches this copy
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sram_bit <= DFLT;
        end else if (recall) begin
            sram_bit <= shadow_bit;
        end else if (wr_en) begin
            sram_bit <= wr_bit;
        end
    end
endmodule

/* bench/bpc_regs_props.sv */
// port checker for the register bank
// assumes it is bound onto bpc_regs and sees only its ports
module bpc_regs_props
    import bpc_pkg::*;
#(
    parameter bit FOUR_CELL = 1'b1
) (
    // clock, reset and instructions
    input wire logic        core_clk, rstn, config_write_instr, control_write_instr,
    input wire logic        array_write_instr,
    input wire logic [15:0] wr_data,
    input wire logic        sleep_supply_threshold,
    // registers and state
    input wire logic [15:0] protection_configuration, pack_control,
    input wire logic        write_latch, sleep_mode, normal_mode, store_busy,
    // decoded outputs
    input wire logic [1:0]  overcharge_threshold_sel, undervoltage_threshold_sel,
    input wire logic [1:0]  overcurrent_threshold_sel, charge_enable_level_sel,
    input wire logic        charge_inhibit_disable, charge_inhibit_en, four_cell_select,
    input wire bpc_mv_type  overcharge_mv, undervoltage_mv, overcurrent_mv, charge_enable_mv,
    input wire logic [1:0]  sense_gain_sel,
    input wire logic        charge_fet_pin, discharge_fet_pin,
    input wire logic [3:0]  balance_outputs
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // level tables, one fixed step per code
    AST_OVC: assert property (overcharge_mv == 13'd4200 + 13'd50 * overcharge_threshold_sel)
        else $error("overcharge level wrong");
    AST_UV: assert property (undervoltage_mv ==
        (FOUR_CELL ? 13'd1950 : 13'd2250) + 13'd100 * undervoltage_threshold_sel)
        else $error("undervoltage level wrong");
    AST_OC: assert property (overcurrent_mv == 13'd75 + 13'd25 * overcurrent_threshold_sel)
        else $error("overcurrent level wrong");
    AST_CE: assert property (charge_enable_mv == 13'd500 + 13'd300 * charge_enable_level_sel)
        else $error("charge enable level wrong");
    // field placement and the inverted inhibit sense
    AST_FLD: assert property ({overcharge_threshold_sel, undervoltage_threshold_sel,
        overcurrent_threshold_sel, charge_enable_level_sel, four_cell_select,
        charge_inhibit_disable, charge_inhibit_en} ==
        {protection_configuration[15:6], ~protection_configuration[6]})
        else $error("config fields misplaced");
    AST_OUT: assert property ({balance_outputs, discharge_fet_pin, charge_fet_pin,
        sense_gain_sel} == pack_control[15:8]) else $error("control pins wrong");
    // accepted writes land whole at the taking edge; commit, sleep entry and control clear on wake
    AST_CTLW: assert property (control_write_instr && normal_mode |=>
        pack_control == $past(wr_data)) else $error("control write lost");
    AST_CFGW: assert property (config_write_instr && normal_mode |=>
        protection_configuration == $past(wr_data)) else $error("config write lost");
    AST_STO: assert property (array_write_instr && normal_mode |=>
        store_busy == $past(write_latch) && !write_latch) else $error("commit wrong");
    AST_SLP: assert property ($rose(sleep_mode) |->
        $past(pack_control[7]) && $past(sleep_supply_threshold)) else $error("bad sleep");
    AST_WAKE: assert property ($rose(normal_mode) |-> pack_control == 16'h0000)
        else $error("control not cleared");
    cover property (store_busy);
    cover property ($rose(sleep_mode));
    cover property ($rose(normal_mode) && $past(sleep_mode));
endmodule

bind bpc_regs bpc_regs_props #(.FOUR_CELL(FOUR_CELL)) u_props (.core_clk, .rstn,
    .config_write_instr, .control_write_instr, .array_write_instr, .wr_data,
    .sleep_supply_threshold, .protection_configuration, .pack_control, .write_latch,
    .sleep_mode, .normal_mode, .store_busy, .overcharge_threshold_sel,
    .undervoltage_threshold_sel, .overcurrent_threshold_sel, .charge_enable_level_sel,
    .charge_inhibit_disable, .charge_inhibit_en, .four_cell_select, .overcharge_mv,
    .undervoltage_mv, .overcurrent_mv, .charge_enable_mv, .sense_gain_sel,
    .charge_fet_pin, .discharge_fet_pin, .balance_outputs);

/* bench/bpc_host_model.sv */
// pack host model: issues decoded instructions with their data
// assumes it alone drives the strobes; bit order is wrdi,awr,wen,ctl,cfg
module bpc_host_model
#(
    parameter bit FOUR_CELL = 1'b1
) (
    // clock
    input  wire logic core_clk,
    // instruction strobes and data
    output logic [4:0]  instr,
    output logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        instr = 5'h00;
        wr_data = 16'h0000;
    end
    // strobe spans exactly one rising edge, then data goes stale on purpose
    task automatic issue(input logic [4:0] op, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (op[1]) v = v & 16'hff9f;
        if (op[0] && !FOUR_CELL) v[7] = 1'b0;
        @(negedge core_clk);
        instr = op;
        wr_data = v;
        @(negedge core_clk);
        instr = 5'h00;
        wr_data = ~v; // released data never matches the last word
    endtask
endmodule

/* bench/battery_protect_config_control_regs_bench.sv */
// bench for the register bank: host call sequences against expected values
// assumes the four-cell variant and the host model beside it
module battery_protect_config_control_regs_bench
    import bpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] CFG = 5'h01, CTL = 5'h02, WEN = 5'h04, AWR = 5'h08, WRDI = 5'h10;
    logic       core_clk = 1'b0, rstn = 1'b0, thr = 1'b0, wake = 1'b0;
    logic [4:0] instr;
    logic [15:0] wr_data, protection_configuration, pack_control, d;
    logic [1:0] overcharge_threshold_sel, undervoltage_threshold_sel, k;
    logic [1:0] overcurrent_threshold_sel, charge_enable_level_sel, sense_gain_sel;
    logic       write_latch, charge_inhibit_disable, charge_inhibit_en, four_cell_select;
    logic       charge_fet_pin, discharge_fet_pin, sleep_mode, normal_mode, store_busy;
    logic [3:0] balance_outputs;
    bpc_mv_type overcharge_mv, undervoltage_mv, overcurrent_mv, charge_enable_mv;
    int         n_fail = 0, checks_done = 0, cyc = 0;
    bpc_host_model #(.FOUR_CELL(1'b1)) host (.core_clk, .instr, .wr_data);
    bpc_regs #(.FOUR_CELL(1'b1)) uut (.core_clk, .rstn, .config_write_instr(instr[0]),
        .control_write_instr(instr[1]), .write_enable_instr(instr[2]),
        .array_write_instr(instr[3]), .wrdi_instr(instr[4]), .wr_data,
        .sleep_supply_threshold(thr), .wake_supply(wake), .protection_configuration,
        .pack_control, .write_latch, .overcharge_threshold_sel, .undervoltage_threshold_sel,
        .overcurrent_threshold_sel, .charge_enable_level_sel, .charge_inhibit_disable,
        .charge_inhibit_en, .four_cell_select, .overcharge_mv, .undervoltage_mv,
        .overcurrent_mv, .charge_enable_mv, .sense_gain_sel, .charge_fet_pin,
        .discharge_fet_pin, .balance_outputs, .sleep_mode, .normal_mode, .store_busy);
    always #25 core_clk = ~core_clk;
    // hang guard, tests need about fifty cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("cfg_reset", 16'h33c0, protection_configuration);
        chk("ctl_reset", 16'h0000, pack_control);
        $display("test reset done");
        // every code of every field, bits 5-0 carried along
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            d = {k, k, k, k, k[0], ~k[0], 6'h15};
            host.issue(CFG, d);
            chk("cfg", d, protection_configuration);
            chk("ovc", 16'(4200 + 50 * c), overcharge_mv);
            chk("uv", 16'(1950 + 100 * c), undervoltage_mv);
            chk("oc", 16'(75 + 25 * c), overcurrent_mv);
            chk("ce", 16'(500 + 300 * c), charge_enable_mv);
            chk("inh", k[0], charge_inhibit_en);
            chk("cell", k[0], four_cell_select);
        end
        $display("test config done");
        host.issue(AWR, 16'h0);
        chk("no_latch", 1'b0, store_busy);
        host.issue(WEN, 16'h0);
        chk("latch", 1'b1, write_latch);
        host.issue(WRDI, 16'h0);
        chk("wrdi", 1'b0, write_latch);
        host.issue(WEN, 16'h0);
        host.issue(AWR, 16'h0);
        chk("busy", 1'b1, store_busy);
        chk("cfg_kept", d, protection_configuration);
        $display("test commit done");
        host.issue(CTL, 16'hf77f);
        chk("ctl", 16'hf71f, pack_control);
        for (int b = 8; b < 16; b++) begin
            host.issue(CTL, 16'(1 << b));
            chk("pins", 16'(1 << (b - 8)), {balance_outputs, discharge_fet_pin,
                charge_fet_pin, sense_gain_sel});
        end
        $display("test control done");
        host.issue(CTL, 16'h0c80);
        @(negedge core_clk);
        chk("awake", 1'b0, sleep_mode);
        thr = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("asleep", 1'b1, sleep_mode);
        host.issue(CTL, 16'h0000);
        chk("refused", 16'h0c80, pack_control);
        thr = 1'b0;
        wake = 1'b1;
        repeat (2) @(negedge core_clk);
        wake = 1'b0;
        chk("woken", 1'b1, normal_mode);
        chk("cleared", 16'h0000, pack_control);
        chk("fets_off", 2'b00, {discharge_fet_pin, charge_fet_pin});
        $display("test sleep done");
        tally_and_finish();
    end
endmodule
